// file: rtl/hdlc_tx_pkg.sv
// Purpose: shared constants and types of the transmit overhead packet framer
// Assumes: one 100 MHz clock, synchronous active high reset
// Notes: register offsets are byte addresses on a 32-bit plain register port
package hdlc_tx_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int DEPTH = 256;
  localparam int PTR_W = 8;
  localparam int LVL_W = 9;

  localparam logic [ADDR_W-1:0] CTRL_OFF = 4'h0;
  localparam logic [ADDR_W-1:0] THRESH_OFF = 4'h4;
  localparam logic [ADDR_W-1:0] DATA_OFF = 4'h8;
  localparam logic [ADDR_W-1:0] STATUS_OFF = 4'hc;

  localparam int DATA_END_BIT = 8;
  localparam int ST_EMPTY_BIT = 0;
  localparam int ST_SPACE_BIT = 1;
  localparam int ST_FULL_BIT = 2;
  localparam int ST_OVF_BIT = 3;
  localparam int ST_UNF_BIT = 4;
  localparam int ST_LEVEL_LSB = 16;

  // control word, bit 0 is fcs_en ... bit 5 is start_en
  typedef struct packed {
    logic start_en;
    logic invert;
    logic fill_ones;
    logic reorder;
    logic fcs_err;
    logic fcs_en;
  } ctrl_t;

  localparam logic [5:0] CTRL_RESET = 6'h21;
  localparam logic [LVL_W-1:0] THRESH_RESET = 9'h010;
  localparam logic [LVL_W-1:0] FIFO_FULL_LEVEL = 9'h100;
  localparam logic [LVL_W-1:0] START_MIN_LEVEL = 9'h002;
  // level before the packet-end pop; under three leaves under two behind it
  localparam logic [LVL_W-1:0] FILL_MIN_LEVEL = 9'h003;

  localparam logic [7:0] FLAG_OCTET = 8'h7e;
  localparam logic [7:0] ABORT_OCTET = 8'hff;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [2:0] STUFF_RUN = 3'h5;
  localparam logic [4:0] LAST_BYTE_BIT = 5'h07;
  localparam logic [4:0] LAST_FCS_BIT = 5'h0f;
  localparam logic [4:0] ONES_FILL_MIN = 5'h0f;

  typedef struct packed {
    logic pkt_end;
    logic [7:0] data;
  } fifo_entry_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  typedef enum logic [2:0] {
    S_FILL_FLAG = 3'b000,
    S_FILL_ONES = 3'b001,
    S_START = 3'b010,
    S_DATA = 3'b011,
    S_FCS = 3'b100,
    S_END = 3'b101,
    S_ABORT = 3'b110
  } tx_state_t;
endpackage : hdlc_tx_pkg

// file: rtl/hdlc_overhead_tx.sv
// Purpose: transmit queue and serial packet framer for overhead insertion
// Assumes: framer logic shares the clock and pulses bit_req per needed bit
// Notes: the tx bit answers one cycle after each bit_req
`timescale 1ns/1ps
module hdlc_overhead_tx (
  input wire logic clock,
  input wire logic rst,
  input wire hdlc_tx_pkg::reg_req_t bus_req,
  output logic [hdlc_tx_pkg::DATA_W-1:0] rdata,
  input wire logic bit_req,
  output logic tx_bit,
  output logic tx_bit_valid
);

  function automatic logic [7:0] bit_swap(input logic [7:0] b);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[i] = b[7-i];
    end
    return r;
  endfunction : bit_swap

  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic b);
    logic fb;
    fb = b ^ c[15];
    return {c[14:0], 1'b0} ^ (fb ? hdlc_tx_pkg::CRC_POLY : 16'h0000);
  endfunction : crc_step

  // bit 0 of a stored byte leaves first unless the order is reversed
  function automatic logic [7:0] load_byte(input logic [7:0] b,
                                           input logic reorder);
    return reorder ? bit_swap(b) : b;
  endfunction : load_byte

  // judged on the level before the pop of the fetched byte
  function automatic logic fill_follows(
      input logic [hdlc_tx_pkg::LVL_W-1:0] lvl,
      input logic start_en);
    return (lvl < hdlc_tx_pkg::FILL_MIN_LEVEL) || !start_en;
  endfunction : fill_follows

  // register and queue state
  hdlc_tx_pkg::fifo_entry_t mem_q [hdlc_tx_pkg::DEPTH];
  hdlc_tx_pkg::ctrl_t ctrl_q, ctrl_d;
  logic [hdlc_tx_pkg::LVL_W-1:0] thresh_q, thresh_d;
  logic [hdlc_tx_pkg::LVL_W-1:0] level_q, level_d;
  logic [hdlc_tx_pkg::PTR_W-1:0] wr_ptr_q, wr_ptr_d;
  logic [hdlc_tx_pkg::PTR_W-1:0] rd_ptr_q, rd_ptr_d;
  logic ovf_q, ovf_d;
  logic unf_q, unf_d;
  logic [hdlc_tx_pkg::DATA_W-1:0] rdata_q, rdata_d;

  logic q_empty, q_full, q_space, push, push_req, pop, underflow;
  logic pkt_ready;
  hdlc_tx_pkg::fifo_entry_t head;
  hdlc_tx_pkg::fifo_entry_t mem_wd;
  logic [hdlc_tx_pkg::LVL_W-1:0] free_cnt;

  // engine state
  hdlc_tx_pkg::tx_state_t st_q, st_d;
  logic [7:0] sh_q, sh_d;
  logic [4:0] cnt_q, cnt_d;
  logic [2:0] ones_q, ones_d;
  logic [15:0] crc_q, crc_d;
  logic end_q, end_d;
  logic fill_q, fill_d;
  logic out_q, out_d;
  logic valid_q, valid_d;

  assign q_empty = (level_q == '0);
  assign q_full = (level_q == hdlc_tx_pkg::FIFO_FULL_LEVEL);
  // free space, not level, is held against the threshold
  assign free_cnt = hdlc_tx_pkg::FIFO_FULL_LEVEL - level_q;
  assign q_space = (free_cnt >= thresh_q);
  assign head = mem_q[rd_ptr_q];
  // start needs two queued bytes so the first fetches cannot underflow
  assign pkt_ready = (level_q >= hdlc_tx_pkg::START_MIN_LEVEL) &&
                     ctrl_q.start_en;

  assign push_req = bus_req.wr && (bus_req.addr == hdlc_tx_pkg::DATA_OFF);
  assign push = push_req && !q_full;
  // a fetch that finds nothing both flags underflow and aborts the packet
  assign underflow = pop && q_empty;

  always_comb begin
    ctrl_d = ctrl_q;
    thresh_d = thresh_q;
    wr_ptr_d = wr_ptr_q;
    rd_ptr_d = rd_ptr_q;
    level_d = level_q;
    ovf_d = ovf_q;
    unf_d = unf_q;
    // read data is zero outside its answer cycle
    rdata_d = '0;
    if (bus_req.wr) begin
      unique case (bus_req.addr)
        hdlc_tx_pkg::CTRL_OFF: begin
          ctrl_d = bus_req.wdata[5:0];
        end
        hdlc_tx_pkg::THRESH_OFF: begin
          thresh_d = bus_req.wdata[hdlc_tx_pkg::LVL_W-1:0];
        end
        hdlc_tx_pkg::STATUS_OFF: begin
          // write one to clear; a same-cycle event below still wins
          if (bus_req.wdata[hdlc_tx_pkg::ST_OVF_BIT]) begin
            ovf_d = 1'b0;
          end
          if (bus_req.wdata[hdlc_tx_pkg::ST_UNF_BIT]) begin
            unf_d = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    if (push_req && q_full) begin
      ovf_d = 1'b1;
    end
    if (underflow) begin
      unf_d = 1'b1;
    end
    // writes and fetches run independently; a write to a full queue is dropped, a fetch from empty aborts
    if (push) begin
      wr_ptr_d = wr_ptr_q + 8'h01;
    end
    if (pop && !q_empty) begin
      rd_ptr_d = rd_ptr_q + 8'h01;
    end
    level_d = level_q + {8'h00, push} - {8'h00, pop && !q_empty};
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        hdlc_tx_pkg::CTRL_OFF: begin
          rdata_d[5:0] = ctrl_q;
        end
        hdlc_tx_pkg::THRESH_OFF: begin
          rdata_d[hdlc_tx_pkg::LVL_W-1:0] = thresh_q;
        end
        hdlc_tx_pkg::STATUS_OFF: begin
          rdata_d[hdlc_tx_pkg::ST_EMPTY_BIT] = q_empty;
          rdata_d[hdlc_tx_pkg::ST_SPACE_BIT] = q_space;
          rdata_d[hdlc_tx_pkg::ST_FULL_BIT] = q_full;
          rdata_d[hdlc_tx_pkg::ST_OVF_BIT] = ovf_q;
          rdata_d[hdlc_tx_pkg::ST_UNF_BIT] = unf_q;
          rdata_d[hdlc_tx_pkg::ST_LEVEL_LSB +: hdlc_tx_pkg::LVL_W] = level_q;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_q <= hdlc_tx_pkg::CTRL_RESET;
      thresh_q <= hdlc_tx_pkg::THRESH_RESET;
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      level_q <= '0;
      ovf_q <= 1'b0;
      unf_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
      thresh_q <= thresh_d;
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      level_q <= level_d;
      ovf_q <= ovf_d;
      unf_q <= unf_d;
      rdata_q <= rdata_d;
    end
  end

  // write port decoded apart so the store below only registers
  always_comb begin
    mem_wd = '0;
    mem_wd.pkt_end = bus_req.wdata[hdlc_tx_pkg::DATA_END_BIT];
    mem_wd.data = bus_req.wdata[7:0];
  end

  // storage has no reset; contents are only read behind the level count
  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wr_ptr_q] <= mem_wd;
    end
  end

  // serial engine: one output bit per bit_req
  always_comb begin
    st_d = st_q;
    sh_d = sh_q;
    cnt_d = cnt_q;
    ones_d = ones_q;
    crc_d = crc_q;
    end_d = end_q;
    fill_d = fill_q;
    out_d = out_q;
    valid_d = bit_req;
    pop = 1'b0;
    if (bit_req) begin
      if (ones_q == hdlc_tx_pkg::STUFF_RUN) begin
        out_d = 1'b0;
        ones_d = '0;
      end else begin
        unique case (st_q)
          hdlc_tx_pkg::S_FILL_FLAG, hdlc_tx_pkg::S_END,
          hdlc_tx_pkg::S_START, hdlc_tx_pkg::S_ABORT: begin
            out_d = sh_q[0];
            sh_d = {1'b0, sh_q[7:1]};
            cnt_d = cnt_q + 5'h01;
            ones_d = '0;
            if (cnt_q == hdlc_tx_pkg::LAST_BYTE_BIT) begin
              cnt_d = '0;
              sh_d = hdlc_tx_pkg::FLAG_OCTET;
              unique case (st_q)
                hdlc_tx_pkg::S_FILL_FLAG: begin
                  // one fill flag plus the start flag gives at least two
                  if (pkt_ready) begin
                    st_d = hdlc_tx_pkg::S_START;
                  end
                end
                hdlc_tx_pkg::S_START: begin
                  pop = 1'b1;
                  crc_d = hdlc_tx_pkg::CRC_INIT;
                  if (q_empty) begin
                    st_d = hdlc_tx_pkg::S_ABORT;
                    sh_d = hdlc_tx_pkg::ABORT_OCTET;
                  end else begin
                    st_d = hdlc_tx_pkg::S_DATA;
                    sh_d = load_byte(head.data, ctrl_q.reorder);
                    end_d = head.pkt_end;
                    fill_d = fill_follows(level_q, ctrl_q.start_en);
                  end
                end
                default: begin
                  // end flag or abort octet done
                  if (st_q == hdlc_tx_pkg::S_END && !fill_q) begin
                    st_d = hdlc_tx_pkg::S_START;
                  end else if (ctrl_q.fill_ones) begin
                    st_d = hdlc_tx_pkg::S_FILL_ONES;
                  end else begin
                    st_d = hdlc_tx_pkg::S_FILL_FLAG;
                  end
                end
              endcase
            end
          end
          hdlc_tx_pkg::S_FILL_ONES: begin
            out_d = 1'b1;
            ones_d = '0;
            // cnt saturates, so a long ones period never looks short
            if (cnt_q != hdlc_tx_pkg::ONES_FILL_MIN) begin
              cnt_d = cnt_q + 5'h01;
            end
            if ((cnt_q >= (hdlc_tx_pkg::ONES_FILL_MIN - 5'h01)) &&
                pkt_ready) begin
              st_d = hdlc_tx_pkg::S_START;
              cnt_d = '0;
              sh_d = hdlc_tx_pkg::FLAG_OCTET;
            end
          end
          hdlc_tx_pkg::S_DATA: begin
            out_d = sh_q[0];
            sh_d = {1'b0, sh_q[7:1]};
            cnt_d = cnt_q + 5'h01;
            ones_d = sh_q[0] ? ones_q + 3'h1 : 3'h0;
            crc_d = crc_step(crc_q, sh_q[0]);
            if (cnt_q == hdlc_tx_pkg::LAST_BYTE_BIT) begin
              cnt_d = '0;
              if (end_q) begin
                sh_d = hdlc_tx_pkg::FLAG_OCTET;
                if (ctrl_q.fcs_en) begin
                  st_d = hdlc_tx_pkg::S_FCS;
                  // fold in the last bit before the sequence is latched
                  crc_d = crc_step(crc_q, sh_q[0]);
                  if (!ctrl_q.fcs_err) begin
                    crc_d = ~crc_d;
                  end
                end else begin
                  st_d = hdlc_tx_pkg::S_END;
                end
              end else begin
                pop = 1'b1;
                if (q_empty) begin
                  st_d = hdlc_tx_pkg::S_ABORT;
                  sh_d = hdlc_tx_pkg::ABORT_OCTET;
                  ones_d = '0;
                end else begin
                  sh_d = load_byte(head.data, ctrl_q.reorder);
                  end_d = head.pkt_end;
                  fill_d = fill_follows(level_q, ctrl_q.start_en);
                end
              end
            end
          end
          hdlc_tx_pkg::S_FCS: begin
            out_d = crc_q[15];
            crc_d = {crc_q[14:0], 1'b0};
            cnt_d = cnt_q + 5'h01;
            ones_d = crc_q[15] ? ones_q + 3'h1 : 3'h0;
            if (cnt_q == hdlc_tx_pkg::LAST_FCS_BIT) begin
              cnt_d = '0;
              st_d = hdlc_tx_pkg::S_END;
              sh_d = hdlc_tx_pkg::FLAG_OCTET;
            end
          end
          default: begin
            st_d = hdlc_tx_pkg::S_FILL_FLAG;
            sh_d = hdlc_tx_pkg::FLAG_OCTET;
            cnt_d = '0;
          end
        endcase
      end
      // inverted last, so stuffing and the check sequence see true data
      out_d = out_d ^ ctrl_q.invert;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_q <= hdlc_tx_pkg::S_FILL_FLAG;
      sh_q <= hdlc_tx_pkg::FLAG_OCTET;
      cnt_q <= '0;
      ones_q <= '0;
      crc_q <= hdlc_tx_pkg::CRC_INIT;
      end_q <= 1'b0;
      fill_q <= 1'b1;
      out_q <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      st_q <= st_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      ones_q <= ones_d;
      crc_q <= crc_d;
      end_q <= end_d;
      fill_q <= fill_d;
      out_q <= out_d;
      valid_q <= valid_d;
    end
  end

  assign tx_bit = out_q;
  assign tx_bit_valid = valid_q;
  assign rdata = rdata_q;

endmodule : hdlc_overhead_tx

// file: verification/hdlc_overhead_tx_checker.sv
// Purpose: port assertions for the overhead packet framer
// Assumes: one clock, synchronous active high reset
// Notes: threshold is shadowed from bus writes to judge the space flag
`timescale 1ns/1ps
module hdlc_overhead_tx_checker (
  input wire logic clock,
  input wire logic rst,
  input wire hdlc_tx_pkg::reg_req_t bus_req,
  input wire logic [hdlc_tx_pkg::DATA_W-1:0] rdata,
  input wire logic bit_req,
  input wire logic tx_bit,
  input wire logic tx_bit_valid
);
  logic [8:0] thr_q;
  logic [8:0] thr_d;
  logic st_q;
  logic st_d;
  logic [8:0] lvl;
  assign lvl = rdata[24:16];
  always_comb begin
    thr_d = thr_q;
    if (bus_req.wr && bus_req.addr == hdlc_tx_pkg::THRESH_OFF) begin
      thr_d = bus_req.wdata[8:0];
    end
    st_d = bus_req.rd && bus_req.addr == hdlc_tx_pkg::STATUS_OFF;
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      thr_q <= hdlc_tx_pkg::THRESH_RESET;
      st_q <= 1'b0;
    end else begin
      thr_q <= thr_d;
      st_q <= st_d;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  bit_answer_a: assert property (bit_req |=> tx_bit_valid)
    else $error("bit request not answered");
  bit_quiet_a: assert property (!bit_req |=> !tx_bit_valid)
    else $error("bit valid without request");
  bit_hold_a: assert property (!bit_req |=> $stable(tx_bit))
    else $error("tx bit moved without request");
  rdata_idle_a: assert property (!bus_req.rd |=> rdata == '0)
    else $error("read data outside read answer");
  empty_flag_a: assert property (st_q |-> rdata[0] == (lvl == 9'h0))
    else $error("empty flag disagrees with level");
  full_flag_a: assert property (st_q |-> rdata[2] == (lvl == 9'h100))
    else $error("full flag disagrees with level");
  level_bound_a: assert property (st_q |-> lvl <= 9'h100)
    else $error("level above capacity");
  space_flag_a: assert property (st_q |-> rdata[1] ==
    ((10'h100 - {1'b0, lvl}) >= {1'b0, $past(thr_q)}))
    else $error("space flag disagrees with threshold");
endmodule : hdlc_overhead_tx_checker

bind hdlc_overhead_tx hdlc_overhead_tx_checker i_hdlc_overhead_tx_checker (
  .clock(clock), .rst(rst), .bus_req(bus_req), .rdata(rdata),
  .bit_req(bit_req), .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid));

// file: verification/hdlc_framer_model.sv
// Purpose: framer side that pulls serial bits and records them
// Assumes: each bit is answered one cycle after its request
// Notes: slow mode asks every other cycle to exercise pacing
`timescale 1ns/1ps
module hdlc_framer_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic run,
  input wire logic slow,
  input wire logic tx_bit,
  input wire logic tx_bit_valid,
  output logic bit_req
);
  logic bits[$];
  logic odd_q;
  always @(posedge clock) begin
    if (rst) begin
      bit_req <= 1'b0;
      odd_q <= 1'b0;
    end else begin
      odd_q <= ~odd_q;
      bit_req <= run && (!slow || odd_q);
      if (tx_bit_valid) begin
        bits.push_back(tx_bit);
      end
    end
  end
endmodule : hdlc_framer_model

// file: verification/test_hdlc_overhead_tx.sv
// Purpose: register driven tests of the transmit packet framer
// Assumes: framer model records every bit it pulls
// Notes: frames are found by searching the recorded stream
`timescale 1ns/1ps
module test_hdlc_overhead_tx;
  logic clock = 1'b0;
  logic rst = 1'b1;
  hdlc_tx_pkg::reg_req_t bus_req = '0;
  logic [31:0] rdata;
  logic bit_req;
  logic tx_bit;
  logic tx_bit_valid;
  logic run = 1'b0;
  logic slow = 1'b0;
  logic exp_q[$];
  logic [7:0] pk[$] = '{8'hff, 8'h7e, 8'h3c};
  logic [5:0] ctrls[6] = '{6'h21, 6'h23, 6'h20, 6'h25, 6'h31, 6'h29};
  logic [15:0] crc;
  logic [31:0] r;
  hdlc_tx_pkg::ctrl_t c;
  int n_errors = 0;
  int checked = 0;
  int run1;
  always #5 clock = ~clock;
  hdlc_overhead_tx i_hdlc_overhead_tx (.clock(clock), .rst(rst),
    .bus_req(bus_req), .rdata(rdata), .bit_req(bit_req),
    .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid));
  hdlc_framer_model i_hdlc_framer_model (.clock(clock), .rst(rst),
    .run(run), .slow(slow), .tx_bit(tx_bit),
    .tx_bit_valid(tx_bit_valid), .bit_req(bit_req));

  task automatic summarize();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  task automatic cmp(string what, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : cmp

  task automatic wr(logic [3:0] a, logic [31:0] d);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    bus_req <= '0;
    @(posedge clock);
  endtask : wr

  task automatic rd(logic [3:0] a, output logic [31:0] d);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clock);
    bus_req <= '0;
    #1 d = rdata;
    @(posedge clock);
  endtask : rd

  task automatic send_pkt(bit e);
    foreach (pk[k]) wr(hdlc_tx_pkg::DATA_OFF,
      {23'h0, e && k == pk.size() - 1, pk[k]});
  endtask : send_pkt

  task automatic put(logic b, bit st);
    exp_q.push_back(b);
    run1 = b ? run1 + 1 : 0;
    if (st && run1 == 5) begin
      exp_q.push_back(1'b0);
      run1 = 0;
    end
  endtask : put

  task automatic put_flag();
    for (int i = 0; i < 8; i++) put(hdlc_tx_pkg::FLAG_OCTET[i], 0);
    run1 = 0;
  endtask : put_flag

  task automatic put_pkt(hdlc_tx_pkg::ctrl_t m);
    logic b;
    crc = hdlc_tx_pkg::CRC_INIT;
    run1 = 0;
    foreach (pk[k]) for (int i = 0; i < 8; i++) begin
      b = m.reorder ? pk[k][7-i] : pk[k][i];
      crc = {crc[14:0], 1'b0} ^
        ((crc[15] ^ b) ? hdlc_tx_pkg::CRC_POLY : 16'h0);
      put(b, 1);
    end
    if (m.fcs_en) for (int i = 15; i >= 0; i--)
      put(crc[i] ^ !m.fcs_err, 1);
  endtask : put_pkt

  task automatic pump(int n);
    run <= 1'b1;
    repeat (n) @(posedge clock);
    run <= 1'b0;
    repeat (4) @(posedge clock);
  endtask : pump

  task automatic expect_seen(string what, bit inv);
    int hit;
    hit = 0;
    for (int s = 0; s + exp_q.size() <= i_hdlc_framer_model.bits.size()
         && hit == 0; s++) begin
      hit = 1;
      foreach (exp_q[j])
        if (i_hdlc_framer_model.bits[s+j] !== (exp_q[j] ^ inv)) hit = 0;
    end
    cmp(what, 1, hit);
    exp_q = {};
    i_hdlc_framer_model.bits = {};
  endtask : expect_seen

  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    rd(hdlc_tx_pkg::STATUS_OFF, r);
    cmp("status at reset", 32'h3, r);
    rd(hdlc_tx_pkg::CTRL_OFF, r);
    cmp("ctrl at reset", 32'h21, r);
    rd(hdlc_tx_pkg::THRESH_OFF, r);
    cmp("threshold at reset", 32'h10, r);
    rd(4'h1, r);
    cmp("unmapped read", 32'h0, r);
    // start disabled: the queued packet must wait in fill
    wr(hdlc_tx_pkg::CTRL_OFF, 32'h01);
    send_pkt(1);
    pump(200);
    rd(hdlc_tx_pkg::STATUS_OFF, r);
    cmp("level while held", 32'h3, {23'h0, r[24:16]});
    for (int k = 0; k < 6; k++) begin
      c = hdlc_tx_pkg::ctrl_t'(ctrls[k]);
      slow <= k[0];
      wr(hdlc_tx_pkg::CTRL_OFF, {26'h0, ctrls[k]});
      send_pkt(1);
      put_flag();
      if (k == 0) begin
        put_pkt(c);
        put_flag();
        put_flag();
      end
      put_pkt(c);
      put_flag();
      if (c.fill_ones) begin
        repeat (15) exp_q.push_back(1'b1);
      end else begin
        put_flag();
      end
      pump(400);
      expect_seen("frame stream", c.invert);
    end
    // no packet end: the fetch from empty aborts the packet
    send_pkt(0);
    put_flag();
    put_pkt(hdlc_tx_pkg::ctrl_t'(6'h20));
    for (int i = 0; i < 8; i++) exp_q.push_back(1'b1);
    pump(300);
    expect_seen("abort stream", 0);
    rd(hdlc_tx_pkg::STATUS_OFF, r);
    cmp("underflow", 32'h13, r);
    wr(hdlc_tx_pkg::STATUS_OFF, 32'h18);
    rd(hdlc_tx_pkg::STATUS_OFF, r);
    cmp("underflow cleared", 32'h3, r);
    wr(hdlc_tx_pkg::CTRL_OFF, 32'h00);
    wr(hdlc_tx_pkg::THRESH_OFF, 32'h100);
    for (int i = 0; i < 257; i++)
      wr(hdlc_tx_pkg::DATA_OFF, i[7:0]);
    rd(hdlc_tx_pkg::STATUS_OFF, r);
    cmp("full with overflow", 32'h0100000c, r);
    wr(hdlc_tx_pkg::STATUS_OFF, 32'h8);
    rd(hdlc_tx_pkg::STATUS_OFF, r);
    cmp("overflow cleared", 32'h01000004, r);
    wr(hdlc_tx_pkg::CTRL_OFF, 32'h21);
    r = 32'h0;
    for (int i = 0; i < 20 && r[0] !== 1'b1; i++) begin
      pump(300);
      rd(hdlc_tx_pkg::STATUS_OFF, r);
    end
    cmp("drained", 32'h13, r);
    summarize();
  end
endmodule : test_hdlc_overhead_tx
